// *** hdl/cpk_defines.svh ***
// Constants for the configuration port key access block
`ifndef CPK_DEFINES_SVH
`define CPK_DEFINES_SVH

// ----------------------------------------------------------------
// Port addresses and keys
// ----------------------------------------------------------------
`define CPK_BASE_STRAP_LO   16'h03f0
`define CPK_BASE_STRAP_HI   16'h0370
`define CPK_KEY_ENTER       8'h55
`define CPK_KEY_EXIT        8'haa

// ----------------------------------------------------------------
// Global and per-device register indices
// ----------------------------------------------------------------
`define CPK_IDX_CFG_CTRL    8'h02
`define CPK_IDX_LDN         8'h07
`define CPK_IDX_DEV_ID      8'h20
`define CPK_IDX_DEV_REV     8'h21
`define CPK_IDX_BASE_LO     8'h26
`define CPK_IDX_BASE_HI     8'h27
`define CPK_IDX_ACTIVATE    8'h30

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CPK_SOFT_RST_BIT    0
`define CPK_LDN_RST         8'h00
`define CPK_ACT_RST         8'h00
`define CPK_NUM_LDEV        16
`define CPK_LDN_W           4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CPK_CLK_HZ          10000000
`define CPK_POR_BLOCK_US    500
`define CPK_POR_BLOCK_CYC   ((`CPK_POR_BLOCK_US * (`CPK_CLK_HZ / 1000000)))

`endif

// *** hdl/cpk_pkg.sv ***
// Types for the configuration port key access block
package cpk_pkg;

    // Gray coded: only two states, one bit changes
    typedef enum logic [0:0] {
        CPK_RUN = 1'b0,
        CPK_CFG = 1'b1
    } cpk_state_t;

    typedef enum logic [1:0] {
        CPK_HIT_NONE = 2'b00,
        CPK_HIT_IDX  = 2'b01,
        CPK_HIT_DATA = 2'b11
    } cpk_hit_t;

endpackage

// *** hdl/cpk_sync2.sv ***
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cpk_sync2 (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= 1'b0;
            q_o     <= 1'b0;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule

// *** hdl/cpk_por_timer.sv ***
// Host access blocking timer after power-on
`timescale 1ns/1ps
`include "cpk_defines.svh"
module cpk_por_timer #(
    parameter int unsigned BLOCK_CYC = `CPK_POR_BLOCK_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    output logic      ready_o
);
    logic [15:0] cnt_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff  <= 16'h0000;
            ready_o <= 1'b0;
        end else if (!ready_o) begin
            if (cnt_ff >= 16'(BLOCK_CYC - 1)) begin
                ready_o <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end
endmodule

// *** hdl/cpk_config_port.sv ***
// Configuration port decoder, key lock and index/data register access
`timescale 1ns/1ps
`include "cpk_defines.svh"

module cpk_config_port
    import cpk_pkg::*;
#(
    parameter int unsigned POR_BLOCK_CYC = `CPK_POR_BLOCK_CYC,
    parameter logic [7:0]  DEV_ID_VAL    = 8'h5a, // Arbitrary value
    parameter logic [7:0]  DEV_REV_VAL   = 8'h01  // Arbitrary value
) (
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        hard_reset_input_i,
    input  wire logic        base_strap_i,
    input  wire logic        aen_i,
    input  wire logic        iow_n_i,
    input  wire logic        ior_n_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  data_i,
    output logic [7:0]       data_o,
    output logic             data_oe_n_o,
    output logic             cfg_mode_o,
    output logic [15:0]      port_base_o,
    output logic [`CPK_NUM_LDEV-1:0] ldev_active_o,
    output logic             host_ready_o
);
    // ----------------------------------------------------------------
    // Reset and pin synchronisation
    // ----------------------------------------------------------------
    logic rst_s1_ff;
    logic rst_n;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_ff <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n     <= rst_s1_ff;
        end
    end

    logic hrst_s;
    logic strap_s;
    logic aen_s;
    logic iow_s;
    logic ior_s;

    cpk_sync2 u_sync_hrst (.clk_i(clk_i), .rst_n_i(rst_n),
                           .d_i(hard_reset_input_i), .q_o(hrst_s));
    cpk_sync2 u_sync_strap (.clk_i(clk_i), .rst_n_i(rst_n),
                            .d_i(base_strap_i), .q_o(strap_s));
    cpk_sync2 u_sync_aen (.clk_i(clk_i), .rst_n_i(rst_n),
                          .d_i(aen_i), .q_o(aen_s));
    cpk_sync2 u_sync_iow (.clk_i(clk_i), .rst_n_i(rst_n),
                          .d_i(~iow_n_i), .q_o(iow_s));
    cpk_sync2 u_sync_ior (.clk_i(clk_i), .rst_n_i(rst_n),
                          .d_i(~ior_n_i), .q_o(ior_s));

    // Address and data are stable for the whole strobe, so two
    // register stages aligned to the synchronised strobe suffice
    logic [15:0] addr_d1_ff;
    logic [15:0] addr_ff;
    logic [7:0]  wdat_d1_ff;
    logic [7:0]  wdat_ff;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_d1_ff <= 16'h0000;
            addr_ff    <= 16'h0000;
            wdat_d1_ff <= 8'h00;
            wdat_ff    <= 8'h00;
        end else begin
            addr_d1_ff <= addr_i;
            addr_ff    <= addr_d1_ff;
            wdat_d1_ff <= data_i;
            wdat_ff    <= wdat_d1_ff;
        end
    end

    // ----------------------------------------------------------------
    // Strobe edges and hard reset
    // ----------------------------------------------------------------
    logic iow_d_ff;
    logic ior_d_ff;
    logic hrst_d_ff;
    logic wr_pulse;
    logic rd_start;
    logic hrst_fall;
    logic blocked;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            iow_d_ff  <= 1'b0;
            ior_d_ff  <= 1'b0;
            hrst_d_ff <= 1'b0;
        end else begin
            iow_d_ff  <= iow_s;
            ior_d_ff  <= ior_s;
            hrst_d_ff <= hrst_s;
        end
    end

    logic por_ready;

    cpk_por_timer #(.BLOCK_CYC(POR_BLOCK_CYC)) u_por (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .ready_o (por_ready)
    );

    assign blocked   = !por_ready || hrst_s || aen_s;
    assign wr_pulse  = iow_s && !iow_d_ff && !blocked;
    assign rd_start  = ior_s && !ior_d_ff && !blocked;
    assign hrst_fall = hrst_d_ff && !hrst_s;

    // ----------------------------------------------------------------
    // Base address
    // ----------------------------------------------------------------
    logic        strap_ff;
    logic        strap_seen_ff;
    logic [15:0] base_ff;

    function automatic logic [15:0] strap_base(input logic s);
        strap_base = s ? `CPK_BASE_STRAP_HI : `CPK_BASE_STRAP_LO;
    endfunction

    function automatic cpk_hit_t decode(input logic [15:0] a,
                                        input logic [15:0] b);
        if (a == b) begin
            decode = CPK_HIT_IDX;
        end else if (a == b + 16'h0001) begin
            decode = CPK_HIT_DATA;
        end else begin
            decode = CPK_HIT_NONE;
        end
    endfunction

    // Sync stages hold their reset value just after release, so the
    // strap is followed for the whole power-on block, then at each hard
    // reset end; a block shorter than three cycles would miss it
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_ff      <= 1'b0;
            strap_seen_ff <= 1'b0;
        end else if (!por_ready || hrst_fall) begin
            strap_ff      <= strap_s;
            strap_seen_ff <= 1'b1;
        end
    end

    cpk_state_t  state_ff;
    logic [7:0]  index_ff;
    logic [`CPK_LDN_W-1:0] ldn_ff;
    logic        base_ovr_ff;
    cpk_hit_t    hit;
    logic        soft_rst;

    assign hit = decode(addr_ff, base_ff);
    assign soft_rst = wr_pulse && state_ff == CPK_CFG
                   && hit == CPK_HIT_DATA && index_ff == `CPK_IDX_CFG_CTRL
                   && wdat_ff[`CPK_SOFT_RST_BIT];

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            base_ff     <= `CPK_BASE_STRAP_LO;
            base_ovr_ff <= 1'b0;
        end else if (hrst_s || !strap_seen_ff) begin
            base_ovr_ff <= 1'b0;
        end else if (wr_pulse && state_ff == CPK_CFG
                     && hit == CPK_HIT_DATA) begin
            if (index_ff == `CPK_IDX_BASE_LO) begin
                base_ff[7:0] <= wdat_ff;
                base_ovr_ff  <= 1'b1;
            end else if (index_ff == `CPK_IDX_BASE_HI) begin
                base_ff[15:8] <= wdat_ff;
                base_ovr_ff   <= 1'b1;
            end
        end else if (!base_ovr_ff) begin
            base_ff <= strap_base(strap_ff);
        end
    end

    // ----------------------------------------------------------------
    // Access state machine
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= CPK_RUN;
        end else if (hrst_s) begin
            state_ff <= CPK_RUN;
        end else if (wr_pulse && hit == CPK_HIT_IDX) begin
            case (state_ff)
                CPK_RUN: begin
                    if (wdat_ff == `CPK_KEY_ENTER) begin
                        state_ff <= CPK_CFG;
                    end
                end
                CPK_CFG: begin
                    if (wdat_ff == `CPK_KEY_EXIT) begin
                        state_ff <= CPK_RUN;
                    end
                end
                default: state_ff <= CPK_RUN;
            endcase
        end
    end

    // Index port write; the exit key also lands here, harmlessly
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            index_ff <= 8'h00;
        end else if (hrst_s) begin
            index_ff <= 8'h00;
        end else if (wr_pulse && state_ff == CPK_CFG
                     && hit == CPK_HIT_IDX) begin
            index_ff <= wdat_ff;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ldn_ff <= `CPK_LDN_W'(`CPK_LDN_RST);
        end else if (hrst_s || soft_rst) begin
            ldn_ff <= `CPK_LDN_W'(`CPK_LDN_RST);
        end else if (wr_pulse && state_ff == CPK_CFG
                     && hit == CPK_HIT_DATA
                     && index_ff == `CPK_IDX_LDN) begin
            ldn_ff <= wdat_ff[`CPK_LDN_W-1:0];
        end
    end

    // Per-device activate bits; index below 0x30 is global
    logic [`CPK_NUM_LDEV-1:0] act_ff;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            act_ff <= '0;
        end else if (hrst_s || soft_rst) begin
            act_ff <= '0;
        end else if (wr_pulse && state_ff == CPK_CFG
                     && hit == CPK_HIT_DATA
                     && index_ff == `CPK_IDX_ACTIVATE) begin
            act_ff[ldn_ff] <= wdat_ff[0];
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 8'h00;
        if (hit == CPK_HIT_IDX) begin
            nxt_rdata = index_ff;
        end else if (index_ff == `CPK_IDX_LDN) begin
            nxt_rdata = {{(8-`CPK_LDN_W){1'b0}}, ldn_ff};
        end else if (index_ff == `CPK_IDX_DEV_ID) begin
            nxt_rdata = DEV_ID_VAL;
        end else if (index_ff == `CPK_IDX_DEV_REV) begin
            nxt_rdata = DEV_REV_VAL;
        end else if (index_ff == `CPK_IDX_BASE_LO) begin
            nxt_rdata = base_ff[7:0];
        end else if (index_ff == `CPK_IDX_BASE_HI) begin
            nxt_rdata = base_ff[15:8];
        end else if (index_ff == `CPK_IDX_ACTIVATE) begin
            nxt_rdata = {7'h00, act_ff[ldn_ff]};
        end
    end

    // Key port is write-only: in Run no read is answered
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            data_o      <= 8'h00;
            data_oe_n_o <= 1'b1;
        end else if (rd_start && state_ff == CPK_CFG
                     && hit != CPK_HIT_NONE) begin
            data_o      <= nxt_rdata;
            data_oe_n_o <= 1'b0;
        end else if (!ior_s || aen_s) begin
            data_oe_n_o <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_mode_o    <= 1'b0;
            port_base_o   <= `CPK_BASE_STRAP_LO;
            ldev_active_o <= '0;
            host_ready_o  <= 1'b0;
        end else begin
            cfg_mode_o    <= state_ff == CPK_CFG;
            port_base_o   <= base_ff;
            ldev_active_o <= act_ff;
            host_ready_o  <= por_ready;
        end
    end
endmodule

// *** tb/cpk_config_port_properties.sv ***
// Checker for the configuration port key access block
`timescale 1ns/1ps
`include "cpk_defines.svh"
module cpk_config_port_chk #(
    parameter int unsigned POR_BLOCK_CYC = 20
) (
    input wire logic                     clk_i,
    input wire logic                     arst_n_i,
    input wire logic                     hard_reset_input_i,
    input wire logic                     base_strap_i,
    input wire logic                     aen_i,
    input wire logic                     iow_n_i,
    input wire logic                     ior_n_i,
    input wire logic [15:0]              addr_i,
    input wire logic [7:0]               data_i,
    input wire logic [7:0]               data_o,
    input wire logic                     data_oe_n_o,
    input wire logic                     cfg_mode_o,
    input wire logic [15:0]              port_base_o,
    input wire logic [`CPK_NUM_LDEV-1:0] ldev_active_o,
    input wire logic                     host_ready_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    logic [7:0]  key_hist_ff;
    int unsigned up_cnt_ff;
    wire logic   base_hit = !iow_n_i && !aen_i && addr_i == port_base_o &&
                            host_ready_o && !hard_reset_input_i;

    // --------------------------------------------------------------
    // Recent unlock writes and time since power-on release
    // --------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            key_hist_ff <= 8'h00;
        end else begin
            key_hist_ff <= {key_hist_ff[6:0],
                            base_hit && data_i == `CPK_KEY_ENTER};
        end
    end

    // Saturates so a long run cannot wrap it
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            up_cnt_ff <= 0;
        end else if (up_cnt_ff < POR_BLOCK_CYC + 16) begin
            up_cnt_ff <= up_cnt_ff + 1;
        end
    end

    sequence s_enter;
        base_hit && data_i == `CPK_KEY_ENTER && !cfg_mode_o;
    endsequence
    sequence s_exit;
        base_hit && data_i == `CPK_KEY_EXIT && cfg_mode_o;
    endsequence
    sequence s_junk;
        base_hit && data_i != `CPK_KEY_ENTER && !cfg_mode_o;
    endsequence
    sequence s_aen_key;
        aen_i && !iow_n_i && addr_i == port_base_o &&
        data_i == `CPK_KEY_ENTER && !cfg_mode_o;
    endsequence

    chk_key_enters: assert property (s_enter [*3] |->
        ##[1:6] cfg_mode_o)
        else $error("unlock key did not enter configuration");
    chk_key_exits: assert property (s_exit [*3] |-> ##[1:6] !cfg_mode_o)
        else $error("exit key did not return to run");
    chk_enter_cause: assert property ($rose(cfg_mode_o) |->
        key_hist_ff != 0)
        else $error("configuration entered without unlock key");
    chk_junk_ignored: assert property (s_junk [*3] |=>
        !cfg_mode_o [*5])
        else $error("other key value changed state");
    chk_aen_key: assert property (s_aen_key [*3] |=> !cfg_mode_o [*5])
        else $error("key accepted while address enable high");
    chk_aen_drive: assert property (aen_i [*5] |=> data_oe_n_o)
        else $error("data driven while address enable high");
    chk_read_cfg: assert property (!data_oe_n_o |-> cfg_mode_o)
        else $error("data driven outside configuration");
    chk_hard_reset: assert property (hard_reset_input_i [*6] |=>
        !cfg_mode_o && ldev_active_o == '0)
        else $error("hard reset left device configured");
    chk_strap_base: assert property (hard_reset_input_i ##1
        !hard_reset_input_i [*8] |-> port_base_o == (base_strap_i ?
        `CPK_BASE_STRAP_HI : `CPK_BASE_STRAP_LO))
        else $error("port base does not follow strap");
    chk_por_block: assert property (!host_ready_o |->
        data_oe_n_o && !cfg_mode_o)
        else $error("host access during power-on block");
    chk_ready_early: assert property (host_ready_o |->
        up_cnt_ff >= POR_BLOCK_CYC)
        else $error("host ready too early");
    chk_ready_late: assert property (up_cnt_ff == POR_BLOCK_CYC + 8 |->
        host_ready_o)
        else $error("host ready too late");
endmodule

bind cpk_config_port cpk_config_port_chk #(
    .POR_BLOCK_CYC(POR_BLOCK_CYC)
) u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .hard_reset_input_i(hard_reset_input_i), .base_strap_i(base_strap_i),
    .aen_i(aen_i), .iow_n_i(iow_n_i), .ior_n_i(ior_n_i), .addr_i(addr_i),
    .data_i(data_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
    .cfg_mode_o(cfg_mode_o), .port_base_o(port_base_o),
    .ldev_active_o(ldev_active_o), .host_ready_o(host_ready_o));

// *** tb/cpk_host_model.sv ***
// Host bus controller model issuing I/O read and write cycles
`timescale 1ns/1ps
module cpk_host_model (
    input  wire logic        clk_i,
    input  wire logic [7:0]  rdata_i,
    input  wire logic        oe_n_i,
    output logic             aen_o,
    output logic             iow_n_o,
    output logic             ior_n_o,
    output logic [15:0]      addr_o,
    output logic [7:0]       data_o
);
    initial begin
        aen_o   = 1'b0;
        iow_n_o = 1'b1;
        ior_n_o = 1'b1;
        addr_o  = 16'h0000;
        data_o  = 8'h00;
    end

    // Released lines show the inverse so stale values never look valid
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d,
                         input logic blk);
        @(posedge clk_i);
        aen_o   <= blk;
        addr_o  <= a;
        data_o  <= d;
        iow_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        iow_n_o <= 1'b1;
        aen_o   <= 1'b0;
        addr_o  <= ~a;
        data_o  <= ~d;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic io_rd(input logic [15:0] a, input logic blk,
                         output logic [7:0] d, output logic oe_n);
        @(posedge clk_i);
        aen_o   <= blk;
        addr_o  <= a;
        ior_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        d = rdata_i;
        oe_n = oe_n_i;
        ior_n_o <= 1'b1;
        aen_o   <= 1'b0;
        addr_o  <= ~a;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// *** tb/config_port_key_access_tb.sv ***
// Self-checking testbench for the configuration port key access block
`timescale 1ns/1ps
`include "cpk_defines.svh"
module config_port_key_access_tb;
    localparam int unsigned POR_CYC = 20;
    localparam logic [7:0]  DEV_ID  = 8'h3c; // Arbitrary value
    localparam logic [7:0]  DEV_REV = 8'h02; // Arbitrary value

    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        hard_rst = 1'b0;
    logic        strap = 1'b0;
    wire logic   aen, iow_n, ior_n;
    wire logic [15:0] addr;
    wire logic [7:0]  wdata;
    logic [7:0]  rdata, rd_v, d, lo;
    logic        oe_n, cfg, ready, rd_oe;
    logic [15:0] base, act, b;
    logic [3:0]  ldn;
    int          n_errors = 0;
    int          samples_checked = 0;

    always #50 clk_i = ~clk_i;

    cpk_config_port #(.POR_BLOCK_CYC(POR_CYC), .DEV_ID_VAL(DEV_ID),
        .DEV_REV_VAL(DEV_REV)) u_cpk_config_port (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .hard_reset_input_i(hard_rst),
        .base_strap_i(strap), .aen_i(aen), .iow_n_i(iow_n),
        .ior_n_i(ior_n), .addr_i(addr), .data_i(wdata), .data_o(rdata),
        .data_oe_n_o(oe_n), .cfg_mode_o(cfg), .port_base_o(base),
        .ldev_active_o(act), .host_ready_o(ready));

    cpk_host_model u_host (.clk_i(clk_i), .rdata_i(rdata), .oe_n_i(oe_n),
        .aen_o(aen), .iow_n_o(iow_n), .ior_n_o(ior_n), .addr_o(addr),
        .data_o(wdata));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [15:0] strap_base(input logic s);
        return s ? `CPK_BASE_STRAP_HI : `CPK_BASE_STRAP_LO;
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        u_host.io_wr(a, v, 1'b0);
    endtask

    task automatic rd(input logic [15:0] a);
        u_host.io_rd(a, 1'b0, rd_v, rd_oe);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        $display("unexpected at %0t: run did not complete", $time);
        print_verdict();
    end

    initial begin
        void'($urandom(32'h3493));
        strap <= 1'($urandom);
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        b = strap_base(strap);
        // Key sent inside the power-on block must be dropped
        wr(b, `CPK_KEY_ENTER);
        chk(16'(cfg), 16'h0000);
        chk(16'(ready), 16'h0000);
        for (int i = 0; i < 200 && ready !== 1'b1; i++) @(posedge clk_i);
        chk(base, b);
        chk(16'(cfg), 16'h0000);
        chk(act, 16'h0000);
        rd(b);
        chk(16'(rd_oe), 16'h0001);
        wr(b, `CPK_IDX_LDN);
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? `CPK_KEY_EXIT : 8'($urandom);
            if (d == `CPK_KEY_ENTER) d = 8'h54;
            wr(b, d);
            chk(16'(cfg), 16'h0000);
        end
        u_host.io_wr(b, `CPK_KEY_ENTER, 1'b1);
        chk(16'(cfg), 16'h0000);
        done("run_state");

        wr(b, `CPK_KEY_ENTER);
        chk(16'(cfg), 16'h0001);
        rd(b);
        chk(16'(rd_v), 16'h0000);
        u_host.io_rd(b, 1'b1, rd_v, rd_oe);
        chk(16'(rd_oe), 16'h0001);
        ldn = 4'($urandom);
        wr(b, `CPK_IDX_LDN);
        wr(b + 16'h0001, {4'h0, ldn});
        rd(b + 16'h0001);
        chk(16'(rd_v), {12'h000, ldn});
        wr(b, `CPK_IDX_ACTIVATE);
        wr(b + 16'h0001, 8'h01);
        chk(act, 16'h0001 << ldn);
        rd(b);
        chk(16'(rd_v), 16'(`CPK_IDX_ACTIVATE));
        wr(b, `CPK_IDX_DEV_ID);
        rd(b + 16'h0001);
        chk(16'(rd_v), 16'(DEV_ID));
        wr(b, `CPK_IDX_DEV_REV);
        rd(b + 16'h0001);
        chk(16'(rd_v), 16'(DEV_REV));
        wr(b, `CPK_IDX_CFG_CTRL);
        wr(b + 16'h0001, 8'h01);
        chk(act, 16'h0000);
        wr(b, `CPK_IDX_LDN);
        rd(b + 16'h0001);
        chk(16'(rd_v), 16'(`CPK_LDN_RST));
        done("config_access");

        // Low byte ff puts the data port across a 256-byte boundary
        lo = 8'hff;
        d = 8'($urandom);
        wr(b, `CPK_IDX_BASE_LO);
        wr(b + 16'h0001, lo);
        b = {b[15:8], lo};
        chk(base, b);
        wr(b, `CPK_IDX_BASE_HI);
        wr(b + 16'h0001, d);
        b = {d, lo};
        chk(base, b);
        wr(b, `CPK_IDX_DEV_ID);
        rd(b + 16'h0001);
        chk(16'(rd_v), 16'(DEV_ID));
        wr(b, `CPK_KEY_EXIT);
        chk(16'(cfg), 16'h0000);
        rd(b);
        chk(16'(rd_oe), 16'h0001);
        wr(b, `CPK_KEY_ENTER);
        wr(b, `CPK_IDX_LDN);
        wr(b + 16'h0001, 8'h09);
        wr(b, `CPK_IDX_ACTIVATE);
        wr(b + 16'h0001, 8'h01);
        done("relocate");

        strap <= 1'b1;
        hard_rst <= 1'b1;
        repeat (6) @(posedge clk_i);
        hard_rst <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk(base, strap_base(1'b1));
        chk(16'(cfg), 16'h0000);
        chk(act, 16'h0000);
        strap <= 1'b0;
        repeat (6) @(posedge clk_i);
        b = strap_base(1'b1);
        chk(base, b);
        wr(b, `CPK_KEY_ENTER);
        wr(b, `CPK_IDX_LDN);
        rd(b + 16'h0001);
        chk(16'(rd_v), 16'(`CPK_LDN_RST));
        wr(b, `CPK_KEY_EXIT);
        chk(16'(cfg), 16'h0000);
        done("hard_reset");
        print_verdict();
    end
endmodule
